// ### hdl/pifb_top.sv
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`include "pifb_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pifb_top
  import pifb_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Peripheral events, one-cycle pulses, and the capture/compare mode level
  input  wire logic              conv_done_evt,
  input  wire logic              sync_serial_done_evt,
  input  wire logic              capcmp_capture_evt,
  input  wire logic              capcmp_compare_evt,
  input  wire pifb_ccmode_type   capcmp_mode,
  input  wire logic              period_match_evt,
  input  wire logic              timer16_ovf_evt,
  input  wire logic              osc_fail_evt,
  input  wire logic              nv_write_done_evt,
  // Peripheral levels
  input  wire logic              serial_rx_full,
  input  wire logic              serial_tx_empty,
  input  wire logic              comparator_a_output,
  input  wire logic              comparator_b_output,
  // Interrupt request
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || DATA_W != 32) begin : g_bad_param
    $error("pifb_top: ADDR_W must be at least 5 and DATA_W 32");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2)) ? 1'b1 : 1'b0;
  endfunction

  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic [7:0] clr);
    upd = (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]        sticky_a_q;
  logic [7:0]        sticky_b_q;
  logic [7:0]        ena_a_q;
  logic [7:0]        ena_b_q;
  logic [7:0]        ctrl_q;
  logic              cmpa_prev_q;
  logic              cmpb_prev_q;
  logic              cmp_armed_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_have_q;
  logic [7:0]        wdata_q;
  logic              wlane_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [DATA_W-1:0] rdata_q;

  logic [7:0]        set_a;
  logic [7:0]        set_b;
  logic [7:0]        clr_a;
  logic [7:0]        clr_b;
  logic [7:0]        flags_a;
  logic [7:0]        flags_b;
  logic              do_wr;
  logic              wr_ok;
  logic              rd_take;
  logic              cmpa_chg;
  logic              cmpb_chg;
  logic              cap_hit;
  logic              cmp_hit;

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  // Comparators are watched only after one enabled cycle, so reset
  // does not fake a change when an output idles high.
  assign cmpa_chg = cmp_armed_q & (comparator_a_output ^ cmpa_prev_q);
  assign cmpb_chg = cmp_armed_q & (comparator_b_output ^ cmpb_prev_q);
  assign cap_hit  = (capcmp_mode == PIFB_CC_CAPTURE) & capcmp_capture_evt;
  assign cmp_hit  = (capcmp_mode == PIFB_CC_COMPARE) & capcmp_compare_evt;

  always_comb begin
    set_a = `PIFB_RST_BYTE;
    set_b = `PIFB_RST_BYTE;
    set_a[`PIFB_A_CONV]   = conv_done_evt;
    set_a[`PIFB_A_SSP]    = sync_serial_done_evt;
    set_a[`PIFB_A_CAPCMP] = cap_hit | cmp_hit;
    set_a[`PIFB_A_PERIOD] = period_match_evt;
    set_a[`PIFB_A_T16OVF] = timer16_ovf_evt;
    set_b[`PIFB_B_OSCF]   = osc_fail_evt;
    set_b[`PIFB_B_CMPB]   = cmpb_chg;
    set_b[`PIFB_B_CMPA]   = cmpa_chg;
    set_b[`PIFB_B_NVWR]   = nv_write_done_evt;
    if (do_wr && wlane_q && hit(awaddr_q, `PIFB_OFF_FORCE_A)) begin
      set_a = set_a | wdata_q;
    end
    if (do_wr && wlane_q && hit(awaddr_q, `PIFB_OFF_FORCE_B)) begin
      set_b = set_b | wdata_q;
    end
    set_a = set_a & `PIFB_STICKY_A;
    set_b = set_b & `PIFB_STICKY_B;
  end

  always_comb begin
    clr_a = `PIFB_RST_BYTE;
    clr_b = `PIFB_RST_BYTE;
    if (do_wr && wlane_q && hit(awaddr_q, `PIFB_OFF_FLAGS_A)) begin
      clr_a = wdata_q & `PIFB_STICKY_A;
    end
    if (do_wr && wlane_q && hit(awaddr_q, `PIFB_OFF_FLAGS_B)) begin
      clr_b = wdata_q & `PIFB_STICKY_B;
    end
  end

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sticky_a_q <= `PIFB_RST_BYTE;
      sticky_b_q <= `PIFB_RST_BYTE;
    end else if (clk_en) begin
      sticky_a_q <= upd(sticky_a_q, set_a, clr_a);
      sticky_b_q <= upd(sticky_b_q, set_b, clr_b);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpa_prev_q <= 1'b0;
      cmpb_prev_q <= 1'b0;
      cmp_armed_q <= 1'b0;
    end else if (clk_en) begin
      cmpa_prev_q <= comparator_a_output;
      cmpb_prev_q <= comparator_b_output;
      cmp_armed_q <= 1'b1;
    end
  end

  // Serial flags are live mirrors; the serial port drops them itself
  // on a data read or write, so software cannot clear them here.
  always_comb begin
    flags_a = sticky_a_q & `PIFB_STICKY_A;
    flags_a[`PIFB_A_RX] = serial_rx_full;
    flags_a[`PIFB_A_TX] = serial_tx_empty;
    flags_a = flags_a & `PIFB_IMPL_A;
    flags_b = sticky_b_q & `PIFB_IMPL_B;
  end

  // ----------------------------------------------------------------
  // Enables and interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ena_a_q <= `PIFB_RST_BYTE;
      ena_b_q <= `PIFB_RST_BYTE;
      ctrl_q  <= `PIFB_RST_BYTE;
    end else if (clk_en && do_wr && wlane_q) begin
      if (hit(awaddr_q, `PIFB_OFF_ENA_A)) begin
        ena_a_q <= wdata_q & `PIFB_IMPL_A;
      end
      if (hit(awaddr_q, `PIFB_OFF_ENA_B)) begin
        ena_b_q <= wdata_q & `PIFB_IMPL_B;
      end
      if (hit(awaddr_q, `PIFB_OFF_CTRL)) begin
        ctrl_q <= wdata_q & `PIFB_CTRL_MASK;
      end
    end
  end

  assign irq = ctrl_q[`PIFB_CTRL_GIE] &
               ctrl_q[`PIFB_CTRL_PERIPH_IRQ_GATE] &
               (|((flags_a & ena_a_q) |
                  (flags_b & ena_b_q)));

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are held separately, so either may come first.
  assign s_axi_awready = clk_en & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = clk_en & ~w_have_q & ~bvalid_q;
  assign do_wr         = aw_have_q & w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    wr_ok = hit(awaddr_q, `PIFB_OFF_FLAGS_A) |
            hit(awaddr_q, `PIFB_OFF_FLAGS_B) |
            hit(awaddr_q, `PIFB_OFF_ENA_A) |
            hit(awaddr_q, `PIFB_OFF_ENA_B) |
            hit(awaddr_q, `PIFB_OFF_CTRL) |
            hit(awaddr_q, `PIFB_OFF_FORCE_A) |
            hit(awaddr_q, `PIFB_OFF_FORCE_B);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awaddr_q  <= '0;
      aw_have_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdata_q  <= `PIFB_RST_BYTE;
      wlane_q  <= 1'b0;
      w_have_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata[`PIFB_BYTE_W-1:0];
        wlane_q  <= s_axi_wstrb[0];
        w_have_q <= 1'b1;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PIFB_RESP_OKAY;
    end else if (clk_en) begin
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = clk_en & ~rvalid_q;
  assign rd_take       = s_axi_arvalid & s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `PIFB_RESP_OKAY;
      rdata_q  <= '0;
    end else if (clk_en) begin
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rresp_q  <= `PIFB_RESP_OKAY;
        rdata_q  <= '0;
        if (hit(s_axi_araddr, `PIFB_OFF_FLAGS_A)) begin
          rdata_q[`PIFB_BYTE_W-1:0] <= flags_a;
        end else if (hit(s_axi_araddr, `PIFB_OFF_FLAGS_B)) begin
          rdata_q[`PIFB_BYTE_W-1:0] <= flags_b;
        end else if (hit(s_axi_araddr, `PIFB_OFF_ENA_A)) begin
          rdata_q[`PIFB_BYTE_W-1:0] <= ena_a_q;
        end else if (hit(s_axi_araddr, `PIFB_OFF_ENA_B)) begin
          rdata_q[`PIFB_BYTE_W-1:0] <= ena_b_q;
        end else if (hit(s_axi_araddr, `PIFB_OFF_CTRL)) begin
          rdata_q[`PIFB_BYTE_W-1:0] <= ctrl_q;
        end else if (!hit(s_axi_araddr, `PIFB_OFF_FORCE_A) &&
                     !hit(s_axi_araddr, `PIFB_OFF_FORCE_B)) begin
          rresp_q <= `PIFB_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_irq_gates;
    @(posedge clk) disable iff (sys_rst)
      irq |-> (ctrl_q[`PIFB_CTRL_GIE] && ctrl_q[`PIFB_CTRL_PERIPH_IRQ_GATE]);
  endproperty
  a_irq_gates: assert property (p_irq_gates)
    else $error("irq high while a gate is off");

  property p_conv_sticky;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && conv_done_evt) |=> flags_a[`PIFB_A_CONV] ##1
      (flags_a[`PIFB_A_CONV] || $past(clr_a[`PIFB_A_CONV]));
  endproperty
  a_conv_sticky: assert property (p_conv_sticky)
    else $error("conversion flag not held after event");

  property p_ssp_set;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && sync_serial_done_evt) |=> flags_a[`PIFB_A_SSP];
  endproperty
  a_ssp_set: assert property (p_ssp_set)
    else $error("sync serial flag not set");

  property p_pwm_quiet;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && capcmp_mode == PIFB_CC_PWM && !do_wr &&
       !sticky_a_q[`PIFB_A_CAPCMP]) |=> !sticky_a_q[`PIFB_A_CAPCMP];
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)
    else $error("capture flag set in PWM mode");

  property p_period_set;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && period_match_evt) |=> flags_a[`PIFB_A_PERIOD];
  endproperty
  a_period_set: assert property (p_period_set)
    else $error("period match flag not set");

  property p_t16_hold;
    @(posedge clk) disable iff (sys_rst)
      (sticky_a_q[`PIFB_A_T16OVF] && !clr_a[`PIFB_A_T16OVF])
      |=> sticky_a_q[`PIFB_A_T16OVF];
  endproperty
  a_t16_hold: assert property (p_t16_hold)
    else $error("overflow flag dropped without a clear");

  property p_osc_set;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && osc_fail_evt) |=> flags_b[`PIFB_B_OSCF];
  endproperty
  a_osc_set: assert property (p_osc_set)
    else $error("oscillator fail flag not set");

  property p_cmp_change;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && cmp_armed_q && $changed(comparator_b_output) &&
       $past(clk_en)) |=> flags_b[`PIFB_B_CMPB];
  endproperty
  a_cmp_change: assert property (p_cmp_change)
    else $error("comparator B change not flagged");

  property p_cmpa_change;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && cmpa_chg) |=> flags_b[`PIFB_B_CMPA];
  endproperty
  a_cmpa_change: assert property (p_cmpa_change)
    else $error("comparator A change not flagged");

  property p_nv_set;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && nv_write_done_evt) |=> flags_b[`PIFB_B_NVWR];
  endproperty
  a_nv_set: assert property (p_nv_set)
    else $error("write done flag not set");

  property p_rx_mirror;
    @(posedge clk) disable iff (sys_rst)
      flags_a[`PIFB_A_RX] == serial_rx_full &&
      flags_a[`PIFB_A_TX] == serial_tx_empty;
  endproperty
  a_rx_mirror: assert property (p_rx_mirror)
    else $error("serial flags do not follow buffer state");

  property p_resv_zero;
    @(posedge clk) disable iff (sys_rst)
      rvalid_q |-> (rdata_q[DATA_W-1:`PIFB_BYTE_W] == '0);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("upper read bits not zero");

  property p_irq_cause;
    @(posedge clk) disable iff (sys_rst)
      (ctrl_q[`PIFB_CTRL_GIE] && ctrl_q[`PIFB_CTRL_PERIPH_IRQ_GATE] &&
       ((flags_a & ena_a_q) | (flags_b & ena_b_q)) != '0) |-> irq;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("enabled flag without interrupt");

endmodule

`default_nettype wire

// ### hdl/pifb_defs.svh
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIFB_OFF_FLAGS_A 8'h00
`define PIFB_OFF_FLAGS_B 8'h04
`define PIFB_OFF_ENA_A   8'h08
`define PIFB_OFF_ENA_B   8'h0C
`define PIFB_OFF_CTRL    8'h10
`define PIFB_OFF_FORCE_A 8'h14
`define PIFB_OFF_FORCE_B 8'h18

// ----------------------------------------------------------------
// Flag bit positions, first register
// ----------------------------------------------------------------
`define PIFB_A_CONV      6
`define PIFB_A_RX        5
`define PIFB_A_TX        4
`define PIFB_A_SSP       3
`define PIFB_A_CAPCMP    2
`define PIFB_A_PERIOD    1
`define PIFB_A_T16OVF    0

// ----------------------------------------------------------------
// Flag bit positions, second register
// ----------------------------------------------------------------
`define PIFB_B_OSCF      7
`define PIFB_B_CMPB      6
`define PIFB_B_CMPA      5
`define PIFB_B_NVWR      4

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define PIFB_CTRL_GIE    7
`define PIFB_CTRL_PERIPH_IRQ_GATE   6

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define PIFB_IMPL_A      8'h7F
`define PIFB_IMPL_B      8'hF0
`define PIFB_STICKY_A    8'h4F
`define PIFB_STICKY_B    8'hF0
`define PIFB_CTRL_MASK   8'hC0
`define PIFB_RST_BYTE    8'h00
`define PIFB_BYTE_W      8

// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define PIFB_RESP_OKAY   2'h0
`define PIFB_RESP_SLVERR 2'h2

`endif

// ### hdl/pifb_pkg.sv
package pifb_pkg;

  // ----------------------------------------------------------------
  // Capture/compare unit operating mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIFB_CC_OFF     = 2'h0,
    PIFB_CC_CAPTURE = 2'h1,
    PIFB_CC_COMPARE = 2'h3,
    PIFB_CC_PWM     = 2'h2
  } pifb_ccmode_type;

endpackage

// ### verification/pifb_periph_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Peripheral side: one-cycle event pulses, comparator levels
// ----------------------------------------------------------------
module pifb_periph_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Requests from the bench, one cycle each
  input  wire logic [7:0] evt_req,
  input  wire logic [1:0] cmp_flip,
  // Toward the flag bank
  output logic            conv_done_evt,
  output logic            sync_serial_done_evt,
  output logic            capcmp_capture_evt,
  output logic            capcmp_compare_evt,
  output logic            period_match_evt,
  output logic            timer16_ovf_evt,
  output logic            osc_fail_evt,
  output logic            nv_write_done_evt,
  output logic            comparator_a_output,
  output logic            comparator_b_output
);

  // Pulses are registered so they never overlap a request edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {nv_write_done_evt, osc_fail_evt, timer16_ovf_evt, period_match_evt,
       capcmp_compare_evt, capcmp_capture_evt, sync_serial_done_evt,
       conv_done_evt} <= 8'h00;
    end else begin
      {nv_write_done_evt, osc_fail_evt, timer16_ovf_evt, period_match_evt,
       capcmp_compare_evt, capcmp_capture_evt, sync_serial_done_evt,
       conv_done_evt} <= evt_req;
    end
  end

  // Comparator outputs change level, they are not pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      comparator_a_output <= 1'b0;
      comparator_b_output <= 1'b0;
    end else begin
      comparator_a_output <= comparator_a_output ^ cmp_flip[0];
      comparator_b_output <= comparator_b_output ^ cmp_flip[1];
    end
  end

endmodule

`default_nettype wire

// ### verification/peripheral_irq_flag_bank_tb.sv
`include "pifb_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module peripheral_irq_flag_bank_tb
  import pifb_pkg::*;
;
  typedef struct {
    logic [7:0]      evt;
    logic [1:0]      flip;
    pifb_ccmode_type mode;
    logic [7:0]      exp_a;
    logic [7:0]      exp_b;
  } pifb_row_type;

  logic clk, sys_rst, clk_en, awvalid, wvalid, bready, arvalid, rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, rx_full, tx_empty;
  logic [7:0]  awaddr, araddr, evt;
  logic [31:0] wdata, s_axi_rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, flip;
  logic        ev0, ev1, ev2, ev3, ev4, ev5, ev6, ev7, cmpa, cmpb;
  pifb_ccmode_type mode;
  pifb_row_type    rows [11];
  int miscompares, check_count, i;
  int cycles = 0;

  always #20 clk = ~clk;

  pifb_periph_model model (.clk(clk), .sys_rst(sys_rst), .evt_req(evt),
    .cmp_flip(flip), .conv_done_evt(ev0), .sync_serial_done_evt(ev1),
    .capcmp_capture_evt(ev2), .capcmp_compare_evt(ev3),
    .period_match_evt(ev4), .timer16_ovf_evt(ev5), .osc_fail_evt(ev6),
    .nv_write_done_evt(ev7), .comparator_a_output(cmpa),
    .comparator_b_output(cmpb));

  pifb_top uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(rready), .conv_done_evt(ev0),
    .sync_serial_done_evt(ev1), .capcmp_capture_evt(ev2),
    .capcmp_compare_evt(ev3), .capcmp_mode(mode), .period_match_evt(ev4),
    .timer16_ovf_evt(ev5), .osc_fail_evt(ev6), .nv_write_done_evt(ev7),
    .serial_rx_full(rx_full), .serial_tx_empty(tx_empty),
    .comparator_a_output(cmpa), .comparator_b_output(cmpb), .irq(irq));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Runs well under a thousand cycles; the ceiling only cuts a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    output logic [1:0] rs);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, clk_en, sys_rst} = 3'b011;
    {awvalid, wvalid, bready, arvalid, rready, rx_full, tx_empty} = 7'h00;
    {awaddr, araddr, evt, flip, wdata} = '0;
    {miscompares, check_count} = '0;
    wstrb = 4'hF;
    mode = PIFB_CC_OFF;
    rows[0] = '{8'h01, 2'h0, PIFB_CC_OFF, 8'h40, 8'h00};
    rows[1] = '{8'h02, 2'h0, PIFB_CC_OFF, 8'h08, 8'h00};
    rows[2] = '{8'h04, 2'h0, PIFB_CC_CAPTURE, 8'h04, 8'h00};
    rows[3] = '{8'h08, 2'h0, PIFB_CC_COMPARE, 8'h04, 8'h00};
    rows[4] = '{8'h0C, 2'h0, PIFB_CC_PWM, 8'h00, 8'h00};
    rows[5] = '{8'h10, 2'h0, PIFB_CC_OFF, 8'h02, 8'h00};
    rows[6] = '{8'h20, 2'h0, PIFB_CC_OFF, 8'h01, 8'h00};
    rows[7] = '{8'h40, 2'h0, PIFB_CC_OFF, 8'h00, 8'h80};
    rows[8] = '{8'h80, 2'h0, PIFB_CC_OFF, 8'h00, 8'h10};
    rows[9] = '{8'h00, 2'h2, PIFB_CC_OFF, 8'h00, 8'h40};
    rows[10] = '{8'h00, 2'h1, PIFB_CC_OFF, 8'h00, 8'h20};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Enables stay zero: every sticky flag must still set, except capture/compare in PWM mode
    for (i = 0; i < 11; i++) begin
      mode <= rows[i].mode;
      evt <= rows[i].evt;
      flip <= rows[i].flip;
      @(posedge clk);
      evt <= 8'h00;
      flip <= 2'h0;
      repeat (4) @(posedge clk);
      rd(`PIFB_OFF_FLAGS_A, d, r);
      check("flags_a", d, {24'h0, rows[i].exp_a});
      rd(`PIFB_OFF_FLAGS_B, d, r);
      check("flags_b", d, {24'h0, rows[i].exp_b});
      rd(`PIFB_OFF_FLAGS_A, d, r);
      check("flags_a_held", d, {24'h0, rows[i].exp_a});
      wr(`PIFB_OFF_FLAGS_A, 8'hFF, r);
      wr(`PIFB_OFF_FLAGS_B, 8'hFF, r);
    end
    wr(`PIFB_OFF_FORCE_A, 8'hFF, r);
    wr(`PIFB_OFF_FORCE_B, 8'hFF, r);
    check("write_resp", {30'h0, r}, {30'h0, `PIFB_RESP_OKAY});
    rd(`PIFB_OFF_FLAGS_A, d, r);
    check("forced_a", d, 32'h0000004F);
    rd(`PIFB_OFF_FLAGS_B, d, r);
    check("forced_b", d, 32'h000000F0);
    wr(`PIFB_OFF_FLAGS_A, 8'hFF, r);
    wr(`PIFB_OFF_FLAGS_B, 8'hFF, r);
    wr(`PIFB_OFF_ENA_A, 8'h40, r);
    wr(`PIFB_OFF_FORCE_A, 8'h40, r);
    wr(`PIFB_OFF_CTRL, 8'h80, r);
    @(posedge clk);
    check("irq_no_gate", {31'h0, irq}, 32'h0);
    wr(`PIFB_OFF_CTRL, 8'h40, r);
    @(posedge clk);
    check("irq_no_global", {31'h0, irq}, 32'h0);
    wr(`PIFB_OFF_CTRL, 8'hC0, r);
    @(posedge clk);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(`PIFB_OFF_FLAGS_A, 8'h40, r);
    @(posedge clk);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    repeat (2) @(posedge clk);
    wr(`PIFB_OFF_FLAGS_A, 8'h30, r);
    rd(`PIFB_OFF_FLAGS_A, d, r);
    check("serial_live_hi", d, 32'h00000030);
    rx_full <= 1'b0;
    tx_empty <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`PIFB_OFF_FLAGS_A, d, r);
    check("serial_live_lo", d, 32'h00000000);
    wr(8'h1C, 8'hFF, r);
    check("unmapped_wr", {30'h0, r}, {30'h0, `PIFB_RESP_SLVERR});
    rd(8'h1C, d, r);
    check("unmapped_rd", {30'h0, r}, {30'h0, `PIFB_RESP_SLVERR});
    // Mid-run reset with first-register flags, one first-register enable and both gates set
    wr(`PIFB_OFF_FORCE_A, 8'hFF, r);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq_reset", {31'h0, irq}, 32'h0);
    for (i = 0; i < 7; i++) begin
      rd(8'(i * 4), d, r);
      check("reset_value", d, 32'h00000000);
      check("read_resp", {30'h0, r}, {30'h0, `PIFB_RESP_OKAY});
    end
    report_and_stop();
  end

endmodule

`default_nettype wire
